// ==== inc/eeprom_pkg.sv ====
// Purpose: Shared constants and types for the page-write and protection block.
// Assumes: 20 MHz system clock; the serial clock is the link clock.
// Notes:   Every figure the block uses is named here once.
`default_nettype none

package eeprom_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam int unsigned HZ_PER_MHZ   = 1_000_000;
  localparam int unsigned T_WRITE_US   = 5000;
  localparam int unsigned WRITE_CYCLES = T_WRITE_US * (CLK_HZ / HZ_PER_MHZ);

  // ----------------------------------------------------------------------
  // Framing and layout
  // ----------------------------------------------------------------------
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned PAGE_BYTES = 16;
  localparam int unsigned IDX_W      = 4;
  localparam int unsigned PAGE_W     = 4;
  localparam logic [3:0]  BIT_LAST   = 4'h7;
  localparam logic [3:0]  BIT_ACK    = 4'h8;
  localparam logic [3:0]  DEV_NORMAL = 4'hA;
  localparam logic [3:0]  DEV_PROT   = 4'h6;
  localparam int unsigned UPPER_BIT  = 3;

  // Select levels of the reversible command; the middle bit picks set or clear.
  localparam logic REV_SEL2 = 1'b0;
  localparam logic REV_SEL0 = 1'b1;
  localparam logic SET_SEL1 = 1'b0;

  // Flag values of a device as delivered.
  localparam logic PERM_RESET = 1'b0;
  localparam logic REV_RESET  = 1'b0;

  // ----------------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_DEV  = 2'b00,
    PH_ADDR = 2'b01,
    PH_DATA = 2'b10,
    PH_SKIP = 2'b11
  } phase_t;

  typedef enum logic [1:0] {
    K_ARRAY    = 2'b00,
    K_SET_REV  = 2'b01,
    K_CLR_REV  = 2'b10,
    K_SET_PERM = 2'b11
  } kind_t;

  typedef enum logic [1:0] {
    PG_IDLE   = 2'b00,
    PG_STREAM = 2'b01,
    PG_WAIT   = 2'b10
  } prog_t;

endpackage

`default_nettype wire

// ==== design/sync2.sv ====
// Purpose: Two-flop level synchroniser, any width.
// Assumes: Each bit is an independent level.
// Notes:   Stage one feeds only stage two.
`default_nettype none

module sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         en,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;

  sync_t r;
  sync_t next_r;

  // The second stage only ever reads the first.
  always_comb
  begin
    next_r    = r;
    next_r.s1 = d;
    next_r.s2 = r.s1;
  end

  // Frozen while the enable is low.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      r <= '0;
    else if (en)
      r <= next_r;
  end

  assign q = r.s2;

endmodule

`default_nettype wire

// ==== design/page_buffer.sv ====
// Purpose: Page buffer with a write port on the link clock and a read port
//          on the system clock.
// Assumes: The two ports are never active at once for the same entry.
// Notes:   Read data come out of a register, one cycle after the address.
`default_nettype none

module page_buffer #(
  parameter int unsigned DEPTH = 16,
  parameter int unsigned WIDTH = 8,
  parameter int unsigned AW    = 4
) (
  input  wire logic             wclk,
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic             rclk,
  input  wire logic             rce,
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Write side, filled byte by byte while a frame is on the bus.
  always_ff @(posedge wclk)
  begin
    if (we)
      mem[waddr] <= wdata;
  end

  // Read side, drained only while the link logic is held idle.
  always_ff @(posedge rclk)
  begin
    if (rce)
      rdata <= mem[raddr];
  end

endmodule

`default_nettype wire

// ==== design/eeprom_page_write_protect.sv ====
// Purpose: Write side of a two-wire serial EEPROM slave: page writes,
//          busy polling and lower-half write protection.
// Assumes: Start-to-first-fall hold is longer than four system clocks.
// Notes:   Array bytes leave on the prog port during the write cycle.
`default_nettype none

module eeprom_page_write_protect #(
  parameter int unsigned WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       clk_en,
  input  wire logic       nrst,
  input  wire logic       scl,
  input  wire logic       sda_in,
  output var  logic       sda_out,
  output var  logic       sda_oe,
  input  wire logic       write_protect_pin,
  input  wire logic       addr_select_bit0,
  input  wire logic       addr_select_bit1,
  input  wire logic       addr_select_bit2,
  input  wire logic       extra_high_voltage_level,
  output var  logic       write_busy,
  output var  logic       permanent_protect_flag,
  output var  logic       reversible_protect_flag,
  output var  logic       prog_we,
  output var  logic [7:0] prog_addr,
  output var  logic [7:0] prog_data
);

  localparam int unsigned CW = $clog2(WRITE_CYCLES + 1);
  localparam logic [CW-1:0] W_LAST = CW'(WRITE_CYCLES - 1);
  localparam int unsigned PB = eeprom_pkg::PAGE_BYTES;
  localparam int unsigned IW = eeprom_pkg::IDX_W;
  localparam int unsigned DW = eeprom_pkg::DATA_W;

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic [1:0] rst_q;
  logic       rst_n;

  // Two flops release the reset cleanly on the system clock.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rst_q <= 2'h0;
    else
      rst_q <= {rst_q[0], 1'b1};
  end
  assign rst_n = rst_q[1];

  // ----------------------------------------------------------------------
  // Link domain, clocked by the serial clock
  // ----------------------------------------------------------------------
  typedef struct packed {
    eeprom_pkg::phase_t phase;
    eeprom_pkg::kind_t  kind;
    logic [3:0]         bit_cnt;
    logic [DW-1:0]      shreg;
    logic               ack;
    logic [7:0]         ptr;
    logic [PB-1:0]      mask;
    logic               armed;
    logic               wp_high;
    logic               tog;
  } link_t;

  link_t      l;
  link_t      next_l;
  logic       link_rst_n;
  logic [6:0] lsync;
  logic       l_wp;
  logic       l_hv;
  logic [2:0] l_sel;
  logic       l_perm;
  logic       l_rev;
  logic [7:0] rx_byte;
  logic       buf_we;
  logic       oe_q;
  logic       perm_q;
  logic       rev_q;

  // Pins and flags arrive as levels; they settle well before a byte ends.
  sync2 #(
    .W (7)
  ) u_lsync (
    .clk   (scl),
    .en    (1'b1),
    .rst_n (link_rst_n),
    .d     ({write_protect_pin, extra_high_voltage_level, addr_select_bit2,
             addr_select_bit1, addr_select_bit0, perm_q, rev_q}),
    .q     (lsync)
  );
  assign {l_wp, l_hv, l_sel, l_perm, l_rev} = lsync;

  assign rx_byte = {l.shreg[DW-2:0], sda_in};

  // Byte framing, address decode and the acknowledge decision.
  always_comb
  begin
    next_l = l;
    buf_we = 1'b0;
    if (l_wp)
      next_l.wp_high = 1'b1;
    if (l.bit_cnt == eeprom_pkg::BIT_ACK)
    begin
      next_l.bit_cnt = 4'h0;
      if (!l.ack)
        next_l.phase = eeprom_pkg::PH_SKIP;
    end
    else
    begin
      next_l.shreg   = rx_byte;
      next_l.bit_cnt = l.bit_cnt + 4'h1;
      if (l.bit_cnt == eeprom_pkg::BIT_LAST)
      begin
        next_l.ack = 1'b0;
        case (l.phase)
          eeprom_pkg::PH_DEV:
          begin
            next_l.phase = eeprom_pkg::PH_ADDR;
            next_l.kind  = eeprom_pkg::K_ARRAY;
            if (rx_byte[7:4] == eeprom_pkg::DEV_NORMAL)
              // Polling needs no extra test: while busy the link is held.
              next_l.ack = (rx_byte[3:1] == l_sel) && !rx_byte[0];
            else if (rx_byte[7:4] == eeprom_pkg::DEV_PROT && !l_perm)
            begin
              if (l_hv && rx_byte[3] == eeprom_pkg::REV_SEL2 &&
                  rx_byte[1] == eeprom_pkg::REV_SEL0 &&
                  l_sel[2] == eeprom_pkg::REV_SEL2 && rx_byte[2] == l_sel[1])
              begin
                if (rx_byte[0])
                  next_l.ack = !l_rev;
                else if (rx_byte[2] == eeprom_pkg::SET_SEL1)
                begin
                  next_l.ack  = !l_rev;
                  next_l.kind = eeprom_pkg::K_SET_REV;
                end
                else
                begin
                  next_l.ack  = 1'b1;
                  next_l.kind = eeprom_pkg::K_CLR_REV;
                end
              end
              else if (rx_byte[3:1] == l_sel)
              begin
                // Permanent and combined status both answer by this flag.
                next_l.ack  = 1'b1;
                next_l.kind = eeprom_pkg::K_SET_PERM;
              end
              if (rx_byte[0])
                next_l.phase = eeprom_pkg::PH_SKIP;
            end
          end
          eeprom_pkg::PH_ADDR:
          begin
            next_l.ack   = 1'b1;
            next_l.ptr   = rx_byte;
            next_l.phase = eeprom_pkg::PH_DATA;
          end
          eeprom_pkg::PH_DATA:
          begin
            // Protected targets are still acknowledged; the commit decides.
            next_l.ack   = 1'b1;
            next_l.armed = 1'b1;
            next_l.tog   = !l.tog;
            if (l.kind == eeprom_pkg::K_ARRAY)
            begin
              buf_we = 1'b1;
              next_l.mask = l.mask | (PB'(1) << l.ptr[IW-1:0]);
              // Only the low bits count, so the page wraps by itself.
              next_l.ptr[IW-1:0] = l.ptr[IW-1:0] + IW'(1);
            end
          end
          default:
            next_l.ack = 1'b0;
        endcase
      end
    end
  end

  // Held in reset between frames and for the whole write cycle.
  always_ff @(posedge scl or negedge link_rst_n)
  begin
    if (!link_rst_n)
      l <= '0;
    else
      l <= next_l;
  end

  // The acknowledge is driven from the fall of the eighth clock to the fall of the ninth.
  always_ff @(negedge scl or negedge link_rst_n)
  begin
    if (!link_rst_n)
      oe_q <= 1'b0;
    else
      oe_q <= (l.bit_cnt == eeprom_pkg::BIT_ACK) && l.ack;
  end

  assign sda_oe  = oe_q;
  assign sda_out = 1'b0;

  // ----------------------------------------------------------------------
  // Page buffer
  // ----------------------------------------------------------------------
  logic [DW-1:0] rd_data;
  logic [IW-1:0] rd_addr;

  page_buffer #(
    .DEPTH (PB),
    .WIDTH (DW),
    .AW    (IW)
  ) u_buf (
    .wclk  (scl),
    .we    (buf_we),
    .waddr (l.ptr[IW-1:0]),
    .wdata (rx_byte),
    .rclk  (clk),
    .rce   (clk_en),
    .raddr (rd_addr),
    .rdata (rd_data)
  );

  // ----------------------------------------------------------------------
  // System domain: Start and Stop, commit and write cycle
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic                      run;
    logic                      rel;
    logic                      scl_q;
    logic                      sda_q;
    logic                      tog_q;
    logic                      d_armed;
    eeprom_pkg::kind_t         d_kind;
    logic [eeprom_pkg::PAGE_W-1:0] d_page;
    logic [PB-1:0]             d_mask;
    logic                      d_wp;
    logic                      perm;
    logic                      rev;
    eeprom_pkg::prog_t         state;
    logic                      busy;
    logic [CW-1:0]             wcnt;
    logic [IW:0]               idx;
    logic                      rd_valid;
    logic [IW-1:0]             rd_idx;
    logic                      we;
    logic [7:0]                addr;
    logic [DW-1:0]             data;
  } ctl_t;

  ctl_t       c;
  ctl_t       next_c;
  logic [2:0] csync;
  logic       s_scl;
  logic       s_sda;
  logic       s_tog;
  logic       start_ev;
  logic       stop_ev;
  logic       blocked;

  // Bus lines and the byte toggle reach the system clock through two flops.
  sync2 #(
    .W (3)
  ) u_csync (
    .clk   (clk),
    .en    (clk_en),
    .rst_n (rst_n),
    .d     ({scl, sda_in, l.tog}),
    .q     (csync)
  );
  assign {s_scl, s_sda, s_tog} = csync;

  assign start_ev = s_scl && c.scl_q && c.sda_q && !s_sda;
  assign stop_ev  = s_scl && c.scl_q && !c.sda_q && s_sda;
  assign rd_addr  = c.idx[IW-1:0];
  assign blocked  = c.d_wp ||
                    (!c.d_page[eeprom_pkg::UPPER_BIT] && (c.perm || c.rev));

  // Commit control; the link is only released by a Start while idle.
  always_comb
  begin
    next_c          = c;
    next_c.scl_q    = s_scl;
    next_c.sda_q    = s_sda;
    next_c.we       = 1'b0;
    next_c.rd_valid = 1'b0;
    // The descriptor is steady for a whole bit once the toggle moves.
    if (s_tog != c.tog_q)
    begin
      next_c.tog_q = s_tog;
      if (c.run)
      begin
        next_c.d_armed = l.armed;
        next_c.d_kind  = l.kind;
        next_c.d_page  = l.ptr[7:IW];
        next_c.d_mask  = l.mask;
        next_c.d_wp    = l.wp_high;
      end
    end
    if (c.rel)
    begin
      next_c.rel = 1'b0;
      next_c.run = !c.busy;
    end
    if (start_ev)
    begin
      next_c.run = 1'b0;
      next_c.rel = 1'b1;
    end
    if (stop_ev)
    begin
      next_c.run     = 1'b0;
      next_c.d_armed = 1'b0;
      if (c.state == eeprom_pkg::PG_IDLE && c.d_armed)
      begin
        next_c.wcnt = '0;
        next_c.idx  = '0;
        if (c.d_kind == eeprom_pkg::K_ARRAY && !blocked)
        begin
          next_c.state = eeprom_pkg::PG_STREAM;
          next_c.busy  = 1'b1;
        end
        else if (c.d_kind != eeprom_pkg::K_ARRAY && !c.d_wp)
        begin
          next_c.state = eeprom_pkg::PG_WAIT;
          next_c.busy  = 1'b1;
        end
      end
    end
    // Received bytes leave one by one, one cycle after the buffer read.
    if (c.rd_valid && c.d_mask[c.rd_idx])
    begin
      next_c.we   = 1'b1;
      next_c.addr = {c.d_page, c.rd_idx};
      next_c.data = rd_data;
    end
    case (c.state)
      eeprom_pkg::PG_STREAM:
      begin
        next_c.wcnt     = c.wcnt + CW'(1);
        next_c.idx      = c.idx + (IW + 1)'(1);
        next_c.rd_valid = 1'b1;
        next_c.rd_idx   = c.idx[IW-1:0];
        if (c.idx[IW-1:0] == IW'(PB - 1))
          next_c.state = eeprom_pkg::PG_WAIT;
      end
      eeprom_pkg::PG_WAIT:
      begin
        next_c.wcnt = c.wcnt + CW'(1);
        if (c.wcnt >= W_LAST)
        begin
          next_c.state = eeprom_pkg::PG_IDLE;
          next_c.busy  = 1'b0;
          case (c.d_kind)
            eeprom_pkg::K_SET_REV:  next_c.rev  = 1'b1;
            eeprom_pkg::K_CLR_REV:  next_c.rev  = 1'b0;
            eeprom_pkg::K_SET_PERM: next_c.perm = 1'b1;
            default:                next_c.rev  = c.rev;
          endcase
        end
      end
      default:
        next_c.state = (c.state == eeprom_pkg::PG_IDLE) ? next_c.state : eeprom_pkg::PG_IDLE;
    endcase
  end

  // Flags come up as delivered; they have no storage across power loss here.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      c       <= '0;
      c.scl_q <= 1'b1;
      c.sda_q <= 1'b1;
      c.perm  <= eeprom_pkg::PERM_RESET;
      c.rev   <= eeprom_pkg::REV_RESET;
    end
    else if (clk_en)
      c <= next_c;
  end

  assign link_rst_n              = c.run;
  assign perm_q                  = c.perm;
  assign rev_q                   = c.rev;
  assign write_busy              = c.busy;
  assign permanent_protect_flag  = c.perm;
  assign reversible_protect_flag = c.rev;
  assign prog_we                 = c.we;
  assign prog_addr               = c.addr;
  assign prog_data               = c.data;

endmodule

`default_nettype wire

// ==== verif/eeprom_page_write_protect_monitor.sv ====
// Purpose: Port assertions for the page-write and protection block.
// Assumes: Commit side runs on clk; nrst is the raw reset port.
// Notes:   Bound to the design from the foot of this file.
`default_nettype none

module eeprom_page_write_protect_monitor #(
  parameter int unsigned WRITE_CYCLES = 40
) (
  input wire logic       clk,
  input wire logic       clk_en,
  input wire logic       nrst,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       write_busy,
  input wire logic       permanent_protect_flag,
  input wire logic       reversible_protect_flag,
  input wire logic       prog_we,
  input wire logic [7:0] prog_addr
);
  logic [7:0]  last_addr;
  logic        seen;
  logic [4:0]  n_prog;
  int unsigned busy_len;

  // History of one write cycle; cleared between cycles so pages never mix.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      last_addr <= 8'h00;
      seen      <= 1'b0;
      n_prog    <= 5'h00;
      busy_len  <= 0;
    end
    else if (!write_busy)
    begin
      seen     <= 1'b0;
      n_prog   <= 5'h00;
      busy_len <= 0;
    end
    else
    begin
      busy_len <= clk_en ? busy_len + 1 : busy_len;
      if (prog_we)
      begin
        seen      <= 1'b1;
        last_addr <= prog_addr;
        n_prog    <= n_prog + 5'h01;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  property p_prog_busy; @(posedge clk) disable iff (!nrst) prog_we |-> write_busy; endproperty
  a_prog_busy: assert property (p_prog_busy) else $error("commit outside cycle");
  property p_order;
    @(posedge clk) disable iff (!nrst) prog_we && seen
      |-> prog_addr[7:4] == last_addr[7:4] && prog_addr[3:0] > last_addr[3:0];
  endproperty
  a_order: assert property (p_order) else $error("commit order or page wrong");
  property p_max16; @(posedge clk) disable iff (!nrst) prog_we |-> n_prog < 5'h10; endproperty
  a_max16: assert property (p_max16) else $error("more than 16 commits");
  property p_len;
    @(posedge clk) disable iff (!nrst) $fell(write_busy)
      |-> busy_len + 2 >= WRITE_CYCLES && busy_len <= WRITE_CYCLES + 2;
  endproperty
  a_len: assert property (p_len) else $error("write cycle length wrong");
  property p_quiet;
    @(posedge clk) disable iff (!nrst) write_busy && $past(write_busy, 2) |-> !sda_oe;
  endproperty
  a_quiet: assert property (p_quiet) else $error("acknowledge while busy");
  property p_lower;
    @(posedge clk) disable iff (!nrst) prog_we && !prog_addr[7]
      |-> !permanent_protect_flag && !reversible_protect_flag;
  endproperty
  a_lower: assert property (p_lower) else $error("protected byte committed");
  property p_perm;
    @(posedge clk) disable iff (!nrst) permanent_protect_flag |=> permanent_protect_flag;
  endproperty
  a_perm: assert property (p_perm) else $error("permanent flag cleared");
  property p_flag_end;
    @(posedge clk) disable iff (!nrst)
      $changed(reversible_protect_flag) || $rose(permanent_protect_flag)
      |-> $past(write_busy) || $past(write_busy, 2);
  endproperty
  a_flag_end: assert property (p_flag_end) else $error("flag moved outside cycle");
  property p_drain; @(posedge clk) disable iff (!nrst) sda_oe |-> sda_out == 1'b0; endproperty
  a_drain: assert property (p_drain) else $error("data pin driven high");
endmodule

bind eeprom_page_write_protect eeprom_page_write_protect_monitor #(
  .WRITE_CYCLES(WRITE_CYCLES)
) u_monitor (
  .clk(clk), .clk_en(clk_en), .nrst(nrst), .sda_out(sda_out), .sda_oe(sda_oe),
  .write_busy(write_busy), .permanent_protect_flag(permanent_protect_flag),
  .reversible_protect_flag(reversible_protect_flag), .prog_we(prog_we),
  .prog_addr(prog_addr)
);

`default_nettype wire

// ==== verif/i2c_master_model.sv ====
// Purpose: Bus master that frames bytes on the serial link.
// Assumes: The data line has a pull-up; a quarter bit lasts Q ns.
// Notes:   The clock stands high between frames.
`default_nettype none

module i2c_master_model #(
  parameter int Q = 253
) (
  output var logic scl,
  output logic     sda,
  input wire logic sda_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv;

  // The line is low when either party pulls it; released it is high.
  assign sda = drv & ~sda_oe;
  initial
  begin
    scl = 1'b1;
    drv = 1'b1;
  end
  // Start is held two quarters, well above the four system clocks needed.
  task automatic start();
    drv = 1'b1;
    #Q scl = 1'b1;
    #Q drv = 1'b0;
    #(2 * Q) scl = 1'b0;
    #Q;
  endtask
  task automatic stop();
    drv = 1'b0;
    #Q scl = 1'b1;
    #Q drv = 1'b1;
    #(2 * Q);
  endtask
  // Data changes only while the clock is low.
  task automatic bit_io(input logic b, output logic seen);
    drv = b;
    #Q scl = 1'b1;
    #Q seen = sda;
    #Q scl = 1'b0;
    #Q;
  endtask
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask
endmodule

`default_nettype wire

// ==== verif/testbench.sv ====
// Purpose: Self-checking bench for page writes, polling and protection.
// Assumes: Short write cycle of 1000 clocks; selects default low.
// Notes:   Commits are noted in a queue and matched at the prog port.
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, clk_en = 1'b1, nrst = 1'b0, scl, sda, sda_out, sda_oe;
  logic wp = 1'b0, s0 = 1'b0, s1 = 1'b0, s2 = 1'b0, ehv = 1'b0;
  logic write_busy, perm, rev, prog_we;
  logic [7:0]  prog_addr, prog_data;
  logic [2:0]  sel = 3'h0;
  logic [16:0] seed = 17'h18037;
  logic [15:0] exp_q[$];
  int error_cnt = 0, n_tests = 0;

  always #25 clk = ~clk;
  i2c_master_model mst (.scl(scl), .sda(sda), .sda_oe(sda_oe));
  eeprom_page_write_protect #(.WRITE_CYCLES(1000)) dut (
    .clk(clk), .clk_en(clk_en), .nrst(nrst), .scl(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .write_protect_pin(wp),
    .addr_select_bit0(s0), .addr_select_bit1(s1), .addr_select_bit2(s2),
    .extra_high_voltage_level(ehv), .write_busy(write_busy),
    .permanent_protect_flag(perm), .reversible_protect_flag(rev),
    .prog_we(prog_we), .prog_addr(prog_addr), .prog_data(prog_data)
  );

  // ----------------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------------
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Sampled on the falling edge, where the registered port has settled.
  always @(negedge clk)
    if (prog_we === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk("extra commit", 16'h0000, 16'h0001);
      else
        chk("commit", exp_q.pop_front(), {prog_addr, prog_data});
    end
  // Pins change on a clock edge; a refused frame then lets the link see them.
  task automatic pins(input logic w, input logic h, input logic [2:0] s);
    logic a;
    @(posedge clk);
    wp <= w;
    ehv <= h;
    {s2, s1, s0} <= s;
    sel = s;
    mst.start();
    mst.put_byte(8'hF0, a);
    mst.stop();
  endtask
  task automatic send(input logic [7:0] b, input logic e);
    logic a;
    mst.put_byte(b, a);
    chk("ack", {15'h0000, e}, {15'h0000, a});
  endtask
  task automatic poll(input logic e);
    mst.start();
    send({eeprom_pkg::DEV_NORMAL, sel, 1'b0}, e);
    mst.stop();
  endtask
  // Busy must rise within 20 clocks when a cycle is due, else stay low.
  task automatic wait_cycle(input logic c);
    int k;
    k = 0;
    while (write_busy !== 1'b1 && k < 20)
    begin
      @(posedge clk);
      k++;
    end
    chk("busy", {15'h0000, c}, {15'h0000, write_busy});
    k = 0;
    while (write_busy === 1'b1 && k < 1100)
    begin
      @(posedge clk);
      k++;
    end
    repeat (3) @(posedge clk);
    chk("left", 16'h0000, 16'(exp_q.size()));
  endtask
  task automatic write_frame(input logic [7:0] a, input int n, input logic c);
    logic [7:0]  img [16];
    logic [15:0] hit;
    logic [3:0]  ix;
    hit = 16'h0000;
    mst.start();
    send({eeprom_pkg::DEV_NORMAL, sel, 1'b0}, 1'b1);
    send(a, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      seed = lfsr(seed);
      ix = a[3:0] + i[3:0];
      img[ix] = seed[7:0];
      hit[ix] = 1'b1;
      send(seed[7:0], 1'b1);
    end
    for (int j = 0; j < 16; j++)
      if (hit[j] && c) exp_q.push_back({a[7:4], j[3:0], img[j]});
    mst.stop();
    if (c) poll(1'b0);
    wait_cycle(c);
    if (c) poll(1'b1);
  endtask
  // Protection command; write direction carries the two dummies.
  task automatic prot(input logic [7:0] d, input logic e, input logic c);
    mst.start();
    send(d, e);
    if (e && !d[0]) send(8'h00, 1'b1);
    if (e && !d[0]) send(8'h00, 1'b1);
    mst.stop();
    wait_cycle(c);
  endtask
  task automatic flags(input logic p, input logic r);
    chk("flags", {14'h0000, p, r}, {14'h0000, perm, rev});
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (5) @(posedge clk);
    flags(1'b0, 1'b0);
    seed = lfsr(seed);
    pins(1'b0, 1'b0, seed[2:0]);
    write_frame({seed[10:7], 4'hA}, 16, 1'b1);
    write_frame(8'h35, 19, 1'b1);
    pins(1'b1, 1'b0, 3'h0);
    write_frame(8'hC4, 3, 1'b0);
    pins(1'b1, 1'b1, 3'h1);
    prot(8'h63, 1'b1, 1'b0);
    prot(8'h62, 1'b1, 1'b0);
    flags(1'b0, 1'b0);
    pins(1'b0, 1'b1, 3'h1);
    prot(8'h62, 1'b1, 1'b1);
    flags(1'b0, 1'b1);
    prot(8'h63, 1'b0, 1'b0);
    prot(8'h62, 1'b0, 1'b0);
    pins(1'b0, 1'b0, 3'h0);
    write_frame(8'h12, 2, 1'b0);
    write_frame(8'h9E, 4, 1'b1);
    pins(1'b0, 1'b1, 3'h3);
    prot(8'h66, 1'b1, 1'b1);
    flags(1'b0, 1'b0);
    pins(1'b0, 1'b0, 3'h0);
    write_frame(8'h00, 1, 1'b1);
    prot(8'h61, 1'b1, 1'b0);
    prot(8'h60, 1'b1, 1'b1);
    flags(1'b1, 1'b0);
    prot(8'h61, 1'b0, 1'b0);
    write_frame(8'h7F, 2, 1'b0);
    pins(1'b0, 1'b1, 3'h1);
    prot(8'h63, 1'b0, 1'b0);
    end_of_test();
  end
  // A hang is cut short after about three times the expected run.
  initial
  begin
    #4_000_000;
    error_cnt++;
    end_of_test();
  end
endmodule

`default_nettype wire
